// >>> rtl/exec_mask_store.v
// Purpose: per-wavefront execution mask storage
// Assumes: one write and one read per cycle, same clock
// Notes:   read data registered, one cycle after the address
`timescale 1ns/1ps
`default_nettype none

module exec_mask_store (
  input  wire        sys_clk_in,
  input  wire        wr_en_in,
  input  wire [3:0]  wr_addr_in,
  input  wire [63:0] wr_data_in,
  input  wire [3:0]  rd_addr_in,
  output reg  [63:0] rd_data_out
);

  reg [63:0] mem_q [0:15];

  // write port
  always @(posedge sys_clk_in) begin
    if (wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
  end

  // registered read port
  always @(posedge sys_clk_in) begin
    rd_data_out <= mem_q[rd_addr_in];
  end

endmodule

`default_nettype wire

// >>> rtl/shader_classifier_regs.vh
// Purpose: constants for the shader instruction classifier
// Assumes: one 32-bit instruction word per fetch beat
// Notes:   field layout of the first instruction word
`ifndef SHADER_CLASSIFIER_REGS_VH
`define SHADER_CLASSIFIER_REGS_VH

// first-word field positions
`define CLS_HI       31
`define CLS_LO       28
`define OPC_HI       27
`define OPC_LO       20
`define DST_HI       19
`define DST_LO       12
`define AUX_HI       11
`define AUX_LO       8
`define SRC0_HI      7
`define SRC0_LO      0
`define OPC_MASK_WR  7
`define OPC_BITMASK  6
`define OPC_WIDE_RES 7

// instruction classes
`define CLS_SALU     4'h0
`define CLS_SFLOW    4'h1
`define CLS_SFETCH   4'h2
`define CLS_VALU32   4'h3
`define CLS_VALU64   4'h4
`define CLS_VMEM     4'h5
`define CLS_EXPORT   4'h6
`define CLS_SHARED   4'h7

// source code that announces a trailing literal word
`define SRC_LITERAL  8'hff

// operand limits
`define VALU_SRC_MAX 2'h3
`define VALU32_SRCS  2'h2
`define SALU_SRC_MAX 2'h2

// descriptor sizes in scalar register words
`define DESC_NARROW  4'h4
`define DESC_WIDE    4'h8

// fetch destinations
`define DEST_NONE    2'h0
`define DEST_SCALAR  2'h1
`define DEST_VECTOR  2'h2

// thread and wave sizing
`define THREADS      64
`define QUADS        16
`define WAVE_BITS    4
`define WAVES        16
`define EXEC_RESET   64'hffffffffffffffff

`endif

// >>> rtl/shader_instruction_classifier.v
// Purpose: classify the shader instruction stream and size each
//          instruction, carrying per-wave execution masks
// Assumes: fetch path and execution units share sys_clk_in
// Notes:   dec_valid_out is a one-cycle pulse with no stall; the other decoded outputs hold until the next issue
// Overview of operation
// RULE_01: scalar per wavefront, vector per thread
// RULE_02: only scalar instructions change program flow
// RULE_03: vector alu: three operands, value plus mask
// RULE_04: scalar alu: two inputs, one output
// RULE_05: scalar and vector may write execution mask
// RULE_06: vector memory instructions are two words
// RULE_07: export and shared memory are two words
// RULE_08: scalar alu one word plus optional literal
// RULE_09: vector alu one or two words; literal
// RULE_10: literal serves only its own instruction
// RULE_11: program loads sampler into four registers
// RULE_12: program loads resource into four/eight registers
// RULE_13: export copies vector registers to one buffer
// RULE_14: fetch returns to vector or scalar registers
// RULE_15: quads are aligned groups of four threads
// RULE_16: at most eight output surfaces
// RULE_17: 64-bit execution mask, one bit per thread
// RULE_18: finish full length before next instruction
// RULE_19: mask gates vector work, not scalar work
`timescale 1ns/1ps
`default_nettype none
`include "shader_classifier_regs.vh"

module shader_instruction_classifier (
  input  wire        sys_clk_in,
  input  wire        rst_b_in,
  input  wire        fetch_valid_in,
  input  wire [31:0] fetch_word_in,
  input  wire [3:0]  fetch_wave_in,
  output reg         fetch_ready_out,
  input  wire        wave_create_in,
  input  wire [3:0]  wave_create_id_in,
  input  wire        mask_wr_en_in,
  input  wire [3:0]  mask_wr_wave_in,
  input  wire [63:0] mask_wr_data_in,
  output reg         dec_valid_out,
  output reg  [3:0]  dec_class_out,
  output reg  [3:0]  dec_wave_out,
  output reg  [31:0] dec_word_out,
  output reg  [31:0] dec_extra_out,
  output reg         dec_has_literal_out,
  output reg         dec_two_words_out,
  output reg         dec_is_vector_out,
  output reg         dec_is_flow_out,
  output reg         dec_illegal_out,
  output reg  [1:0]  dec_src_count_out,
  output reg         dec_mask_result_out,
  output reg         dec_result_is_mask_out,
  output reg         dec_writes_exec_out,
  output reg  [1:0]  dec_fetch_dest_out,
  output reg  [3:0]  dec_desc_words_out,
  output reg  [1:0]  dec_export_target_out,
  output reg  [2:0]  dec_surface_out,
  output reg         dec_surface_err_out,
  output reg  [63:0] dec_thread_en_out,
  output reg  [15:0] dec_quad_en_out,
  output reg         dec_exec_zero_out
);

  localparam ST_FIRST  = 2'h0;
  localparam ST_SECOND = 2'h1;
  localparam ST_ISSUE  = 2'h2;

  reg [1:0]  state_q;
  reg [1:0]  state_d;
  reg [31:0] word0_q;
  reg [31:0] word1_q;
  reg [3:0]  wave_q;
  reg        lit_q;
  reg [15:0] wave_live_q;

  wire        take;
  wire [3:0]  cls_in;
  wire [3:0]  cls;
  wire [7:0]  opc;
  wire [3:0]  aux;
  wire [63:0] mask_rd;
  wire        mem_we;
  wire [3:0]  mem_waddr;
  wire [63:0] mem_wdata;
  wire [63:0] exec_now;
  wire [63:0] thread_en;
  wire [3:0]  rd_wave;

  // true for classes that always take a second word
  function two_word_class;
    input [3:0] c;
    begin
      two_word_class = (c == `CLS_VALU64) || (c == `CLS_VMEM) ||
                       (c == `CLS_EXPORT) || (c == `CLS_SHARED);
    end
  endfunction

  // true for classes that accept a trailing literal
  function literal_class;
    input [3:0] c;
    begin
      literal_class = (c == `CLS_SALU) || (c == `CLS_VALU32);
    end
  endfunction

  // true for per-thread classes
  function vector_class;
    input [3:0] c;
    begin
      vector_class = (c == `CLS_VALU32) || two_word_class(c);
    end
  endfunction

  assign take   = fetch_valid_in & fetch_ready_out;
  assign cls_in = fetch_word_in[`CLS_HI:`CLS_LO];
  assign cls    = word0_q[`CLS_HI:`CLS_LO];
  assign opc    = word0_q[`OPC_HI:`OPC_LO];
  assign aux    = word0_q[`AUX_HI:`AUX_LO];

  // unit writes win over wave creation on the single write port
  assign mem_we    = mask_wr_en_in | wave_create_in; // see RULE_05
  assign mem_waddr = mask_wr_en_in ? mask_wr_wave_in : wave_create_id_in;
  assign mem_wdata = mask_wr_en_in ? mask_wr_data_in : `EXEC_RESET;

  // address the incoming wave on the edge that takes a first word, so
  // a one-word instruction issues with its own mask, not the last one
  assign rd_wave = (state_q == ST_FIRST) ? fetch_wave_in : wave_q;

  // per-wave 64-bit masks, read on the edge that takes an instruction's last word
  exec_mask_store u_store (
    .sys_clk_in  (sys_clk_in),
    .wr_en_in    (mem_we),
    .wr_addr_in  (mem_waddr),
    .wr_data_in  (mem_wdata),
    .rd_addr_in  (rd_wave),
    .rd_data_out (mask_rd)
  ); // see RULE_17

  // a wave never created reads as all threads off
  assign exec_now = wave_live_q[wave_q] ? mask_rd : 64'h0000000000000000;

  // vector work follows the mask; scalar work ignores it
  assign thread_en = vector_class(cls) ? exec_now : `EXEC_RESET; // see RULE_19

  // live flags for created waves
  always @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      wave_live_q <= 16'h0000;
    end else if (wave_create_in) begin
      wave_live_q[wave_create_id_in] <= 1'b1;
    end
  end

  // sequencer: length is fixed before the next start word
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_FIRST: begin
        if (take) begin
          if (two_word_class(cls_in) ||
              (literal_class(cls_in) &&
               fetch_word_in[`SRC0_HI:`SRC0_LO] == `SRC_LITERAL)) begin
            state_d = ST_SECOND; // see RULE_18
          end else begin
            state_d = ST_ISSUE;
          end
        end
      end
      ST_SECOND: begin
        if (take) begin
          state_d = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        state_d = ST_FIRST;
      end
      default: begin
        state_d = ST_FIRST;
      end
    endcase
  end

  // capture the words of one instruction
  always @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      state_q         <= ST_FIRST;
      fetch_ready_out <= 1'b0;
      word0_q         <= 32'h00000000;
      word1_q         <= 32'h00000000;
      wave_q          <= 4'h0;
      lit_q           <= 1'b0;
    end else begin
      state_q         <= state_d;
      fetch_ready_out <= (state_d != ST_ISSUE);
      if (take && state_q == ST_FIRST) begin
        word0_q <= fetch_word_in;
        word1_q <= 32'h00000000; // see RULE_10
        wave_q  <= fetch_wave_in;
        lit_q   <= literal_class(cls_in) &&
                   fetch_word_in[`SRC0_HI:`SRC0_LO] == `SRC_LITERAL;
      end else if (take && state_q == ST_SECOND) begin
        word1_q <= fetch_word_in; // see RULE_06
      end
    end
  end

  // decoded result, one pulse per instruction
  always @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      dec_valid_out          <= 1'b0;
      dec_class_out          <= 4'h0;
      dec_wave_out           <= 4'h0;
      dec_word_out           <= 32'h00000000;
      dec_extra_out          <= 32'h00000000;
      dec_has_literal_out    <= 1'b0;
      dec_two_words_out      <= 1'b0;
      dec_is_vector_out      <= 1'b0;
      dec_is_flow_out        <= 1'b0;
      dec_illegal_out        <= 1'b0;
      dec_src_count_out      <= 2'h0;
      dec_mask_result_out    <= 1'b0;
      dec_result_is_mask_out <= 1'b0;
      dec_writes_exec_out    <= 1'b0;
      dec_fetch_dest_out     <= `DEST_NONE;
      dec_desc_words_out     <= 4'h0;
      dec_export_target_out  <= 2'h0;
      dec_surface_out        <= 3'h0;
      dec_surface_err_out    <= 1'b0;
      dec_thread_en_out      <= 64'h0000000000000000;
      dec_quad_en_out        <= 16'h0000;
      dec_exec_zero_out      <= 1'b0;
    end else begin
      dec_valid_out <= (state_q == ST_ISSUE);
      if (state_q == ST_ISSUE) begin
        dec_class_out       <= cls;
        dec_wave_out        <= wave_q;
        dec_word_out        <= word0_q;
        dec_extra_out       <= word1_q; // see RULE_10
        dec_has_literal_out <= lit_q; // see RULE_08
        dec_two_words_out   <= two_word_class(cls); // see RULE_07
        dec_is_vector_out   <= vector_class(cls); // see RULE_01
        dec_is_flow_out     <= (cls == `CLS_SFLOW); // see RULE_02
        dec_illegal_out     <= (cls > `CLS_SHARED);
        // operand limits per arithmetic kind
        if (cls == `CLS_VALU64) begin
          dec_src_count_out <= `VALU_SRC_MAX; // see RULE_03
        end else if (cls == `CLS_VALU32) begin
          dec_src_count_out <= `VALU32_SRCS; // see RULE_09
        end else if (cls == `CLS_SALU) begin
          dec_src_count_out <= `SALU_SRC_MAX; // see RULE_04
        end else begin
          dec_src_count_out <= 2'h0;
        end
        dec_mask_result_out <= (cls == `CLS_VALU32) ||
                               (cls == `CLS_VALU64); // see RULE_03
        dec_result_is_mask_out <= (cls == `CLS_SALU) &&
                                  opc[`OPC_BITMASK]; // see RULE_04
        dec_writes_exec_out <= opc[`OPC_MASK_WR] &&
                               ((cls == `CLS_SALU) ||
                                (cls == `CLS_VALU32) ||
                                (cls == `CLS_VALU64)); // see RULE_05
        // where fetched data lands
        if (cls == `CLS_SFETCH) begin
          dec_fetch_dest_out <= `DEST_SCALAR; // see RULE_14
        end else if (cls == `CLS_VMEM) begin
          dec_fetch_dest_out <= `DEST_VECTOR; // see RULE_14
        end else begin
          dec_fetch_dest_out <= `DEST_NONE;
        end
        // descriptor size the program must have loaded
        if (cls == `CLS_VMEM) begin
          dec_desc_words_out <= opc[`OPC_WIDE_RES] ? `DESC_WIDE :
                                `DESC_NARROW; // see RULE_12
        end else begin
          dec_desc_words_out <= 4'h0;
        end
        dec_export_target_out <= (cls == `CLS_EXPORT) ? aux[1:0] :
                                 2'h0; // see RULE_13
        // surface select, only eight reachable
        dec_surface_out     <= aux[2:0];
        dec_surface_err_out <= ((cls == `CLS_VMEM) ||
                                (cls == `CLS_EXPORT)) &&
                               aux[3]; // see RULE_16
        dec_thread_en_out   <= thread_en; // see RULE_19
        dec_quad_en_out     <= quad_or(thread_en); // see RULE_15
        dec_exec_zero_out   <= (exec_now == 64'h0000000000000000);
      end
    end
  end

  // one enable per aligned group of four threads
  function [15:0] quad_or;
    input [63:0] m;
    integer i;
    begin
      quad_or = 16'h0000;
      for (i = 0; i < 16; i = i + 1) begin
        quad_or[i] = |m[4*i +: 4];
      end
    end
  endfunction

endmodule

`default_nettype wire

// >>> verif/cls_checker_assertions.sv
// Purpose: port-level checks on the shader instruction classifier
// Assumes: one clock, synchronous active-low reset
// Notes:   helper logic marks the word that ends an instruction
`timescale 1ns/1ps
`default_nettype none
module cls_checker (
  input wire        sys_clk_in,
  input wire        rst_b_in,
  input wire        fetch_valid_in,
  input wire [31:0] fetch_word_in,
  input wire        fetch_ready_out,
  input wire        dec_valid_out,
  input wire [3:0]  dec_class_out,
  input wire [31:0] dec_word_out,
  input wire        dec_has_literal_out,
  input wire        dec_two_words_out,
  input wire        dec_is_vector_out,
  input wire        dec_is_flow_out,
  input wire [1:0]  dec_src_count_out,
  input wire [63:0] dec_thread_en_out
);
  // which taken word closes an instruction
  wire [3:0] cls   = fetch_word_in[31:28];
  wire       lit   = (cls == 4'h0 || cls == 4'h3) && fetch_word_in[7:0] == 8'hff;
  wire       need2 = lit || (cls >= 4'h4 && cls <= 4'h7);
  wire       take  = fetch_valid_in && fetch_ready_out;
  reg        sec_q;
  wire       last  = take && (sec_q || !need2);
  // next taken word is a second word
  always @(posedge sys_clk_in) begin
    if (!rst_b_in) sec_q <= 1'b0;
    else if (take) sec_q <= !sec_q && need2;
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  property p_issue;
    last |=> !fetch_ready_out ##1 dec_valid_out;
  endproperty
  a_issue: assert property (p_issue) else $error("issue timing");
  property p_cause;
    dec_valid_out |-> $past(last, 2);
  endproperty
  a_cause: assert property (p_cause) else $error("stray decode");
  property p_flow;
    dec_valid_out |-> dec_is_flow_out == (dec_class_out == 4'h1);
  endproperty
  a_flow: assert property (p_flow) else $error("flow flag");
  property p_vec;
    dec_valid_out |-> dec_is_vector_out == (dec_class_out inside {[3:7]});
  endproperty
  a_vec: assert property (p_vec) else $error("vector flag");
  property p_two;
    dec_valid_out |-> dec_two_words_out == (dec_class_out inside {[4:7]});
  endproperty
  a_two: assert property (p_two) else $error("two word flag");
  property p_lit;
    dec_valid_out && dec_has_literal_out |->
      dec_class_out inside {0, 3} && dec_word_out[7:0] == 8'hff;
  endproperty
  a_lit: assert property (p_lit) else $error("literal flag");
  property p_src;
    dec_valid_out && dec_class_out == 4'h4 |-> dec_src_count_out == 2'h3;
  endproperty
  a_src: assert property (p_src) else $error("operand count");
  property p_scal;
    dec_valid_out && !dec_is_vector_out |-> &dec_thread_en_out;
  endproperty
  a_scal: assert property (p_scal) else $error("scalar gated");
  c_last: cover property (last);
  c_lit: cover property (dec_valid_out && dec_has_literal_out);
  c_two: cover property (dec_valid_out && dec_two_words_out);
endmodule
bind shader_instruction_classifier cls_checker u_chk (.*);
`default_nettype wire

// >>> verif/fetch_model.sv
// Purpose: fetch path model handing words to the classifier
// Assumes: words change on the falling edge, taken on the rising edge
// Notes:   released word lines show the inverse of the last word
`timescale 1ns/1ps
`default_nettype none
module fetch_model (
  input  wire        sys_clk_in,
  input  wire        rst_b_in,
  input  wire        go_in,
  input  wire [31:0] word0_in,
  input  wire [31:0] word1_in,
  input  wire        two_in,
  input  wire [3:0]  wave_in,
  input  wire        fetch_ready_in,
  output reg         fetch_valid_out = 1'b0,
  output reg  [31:0] fetch_word_out = 32'h0,
  output reg  [3:0]  fetch_wave_out = 4'h0
);
  reg took_q = 1'b0;
  reg sec_q = 1'b0;
  // note the rising edge that took a word
  always @(posedge sys_clk_in) took_q <= fetch_valid_out && fetch_ready_in;
  // hold each word until taken, then send the second or release
  always @(negedge sys_clk_in) begin
    if (!rst_b_in) begin
      fetch_valid_out <= 1'b0;
      sec_q <= 1'b0;
    end else if (took_q) begin
      if (!sec_q && two_in) begin
        fetch_word_out <= word1_in;
        sec_q <= 1'b1;
      end else begin
        fetch_valid_out <= 1'b0;
        fetch_word_out <= ~fetch_word_out;
        fetch_wave_out <= ~fetch_wave_out;
        sec_q <= 1'b0;
      end
    end else if (go_in && !fetch_valid_out) begin
      fetch_valid_out <= 1'b1;
      fetch_word_out <= word0_in;
      fetch_wave_out <= wave_in;
    end
  end
endmodule
`default_nettype wire

// >>> verif/tb.sv
// Purpose: self-checking bench for the shader instruction classifier
// Assumes: fetch model feeds words; masks driven on falling edges
// Notes:   expected fields are worked out here from the word layout
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        sys_clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        fetch_valid_in, fetch_ready_out, wave_create_in, mask_wr_en_in;
  logic [31:0] fetch_word_in, dec_word_out, dec_extra_out, w0, w1;
  logic [3:0]  fetch_wave_in, wave_create_id_in, mask_wr_wave_in, wv;
  logic [3:0]  dec_class_out, dec_wave_out, dec_desc_words_out;
  logic [63:0] mask_wr_data_in, dec_thread_en_out;
  logic        dec_valid_out, dec_has_literal_out, dec_two_words_out;
  logic        dec_is_vector_out, dec_is_flow_out, dec_illegal_out;
  logic        dec_mask_result_out, dec_result_is_mask_out, dec_writes_exec_out;
  logic [1:0]  dec_src_count_out, dec_fetch_dest_out, dec_export_target_out;
  logic [2:0]  dec_surface_out;
  logic        dec_surface_err_out, dec_exec_zero_out, go, two;
  logic [15:0] dec_quad_en_out;
  logic [63:0] em [16];
  int          bad_count = 0;
  int          check_count = 0;
  // clock and parts
  always #25 sys_clk_in = ~sys_clk_in;
  shader_instruction_classifier DUT (.*);
  fetch_model feeder (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
    .go_in(go), .word0_in(w0), .word1_in(w1), .two_in(two), .wave_in(wv),
    .fetch_ready_in(fetch_ready_out), .fetch_valid_out(fetch_valid_in),
    .fetch_word_out(fetch_word_in), .fetch_wave_out(fetch_wave_in));
  task automatic chk(input string n, input logic [63:0] e, g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish;
    if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // create a wave or write its mask, keeping the expected copy
  task automatic mask_op(input logic cr, wr, input logic [3:0] w,
                         input logic [63:0] d);
    @(negedge sys_clk_in);
    wave_create_in = cr;
    mask_wr_en_in = wr;
    wave_create_id_in = w;
    mask_wr_wave_in = w;
    mask_wr_data_in = d;
    em[w] = wr ? d : (cr ? '1 : em[w]);
    @(negedge sys_clk_in);
    wave_create_in = 1'b0;
    mask_wr_en_in = 1'b0;
  endtask
  // send one instruction and judge its decoded fields
  task automatic run(input logic [31:0] a, b, input logic [3:0] w);
    logic [3:0]  c;
    logic [63:0] m;
    logic [15:0] q;
    logic        vc, lt;
    int          n;
    c = a[31:28];
    lt = (c == 4'h0 || c == 4'h3) && a[7:0] == 8'hff;
    vc = c >= 4'h3 && c <= 4'h7;
    m = vc ? em[w] : '1;
    for (n = 0; n < 16; n++) q[n] = |m[4*n +: 4];
    @(posedge sys_clk_in);
    w0 <= a;
    w1 <= b;
    wv <= w;
    go <= 1'b1;
    two <= lt || (c >= 4'h4 && c <= 4'h7);
    @(posedge sys_clk_in);
    go <= 1'b0;
    n = 0;
    while (dec_valid_out !== 1'b1 && n < 20) begin
      @(negedge sys_clk_in);
      n++;
    end
    chk("valid", 1, dec_valid_out);
    chk("class", c, dec_class_out);
    chk("wave", w, dec_wave_out);
    chk("word", a, dec_word_out);
    chk("extra", two ? b : 0, dec_extra_out);
    chk("literal", lt, dec_has_literal_out);
    chk("two", c >= 4 && c <= 7, dec_two_words_out);
    chk("vector", vc, dec_is_vector_out);
    chk("flow", c == 1, dec_is_flow_out);
    chk("illegal", c > 7, dec_illegal_out);
    chk("srcs", c == 4 ? 3 : (c == 0 || c == 3) ? 2 : 0,
        dec_src_count_out);
    chk("maskres", c == 3 || c == 4, dec_mask_result_out);
    chk("ismask", c == 0 && a[26], dec_result_is_mask_out);
    chk("wrexec", a[27] && c inside {0, 3, 4},
        dec_writes_exec_out);
    chk("dest", c == 2 ? 1 : c == 5 ? 2 : 0, dec_fetch_dest_out);
    chk("desc", c == 5 ? (a[27] ? 8 : 4) : 0,
        dec_desc_words_out);
    chk("target", c == 6 ? a[9:8] : 0, dec_export_target_out);
    chk("surface", a[10:8], dec_surface_out);
    chk("surferr", c inside {5, 6} && a[11],
        dec_surface_err_out);
    chk("threads", m, dec_thread_en_out);
    chk("quads", q, dec_quad_en_out);
    chk("zero", em[w] == 0, dec_exec_zero_out);
    @(negedge sys_clk_in);
    chk("pulse", 0, dec_valid_out);
  endtask
  // every class, with both opcode patterns
  task automatic t_classes;
    for (int k = 0; k < 9; k++) begin
      run({k[3:0], 8'hc0, 8'h12, 4'ha, 8'h01}, 32'h5a5a_0000 + k, 4'h2);
      run({k[3:0], 8'h00, 8'h34, 4'h5, 8'h02}, 32'ha5a5_0000 + k, 4'h2);
    end
  endtask
  // literal words, refused on the wrong classes, used once only
  task automatic t_literal;
    run({4'h0, 20'h0_1000, 8'hff}, 32'hdead_beef, 4'h2);
    run({4'h3, 20'h0_2000, 8'hff}, 32'h3f80_0000, 4'h2);
    run({4'h4, 20'h0_3000, 8'hff}, 32'h1234_5678, 4'h2);
    run({4'h1, 20'h0_4000, 8'hff}, 32'hffff_0000, 4'h2);
    run({4'h0, 20'h0_5000, 8'h10}, 32'h7777_7777, 4'h2);
  endtask
  // per-wave masks, write beating create, a never-created wave
  task automatic t_masks;
    mask_op(1'b1, 1'b0, 4'h5, '0);
    mask_op(1'b0, 1'b1, 4'h5, 64'h00f0_0000_0000_0f01);
    mask_op(1'b1, 1'b1, 4'h9, 64'h0123_4567_89ab_cdef);
    run({4'h3, 28'h000_0001}, 32'h0, 4'h5);
    run({4'h5, 28'h000_0002}, 32'h9, 4'h9);
    run({4'h6, 28'h000_0003}, 32'h6, 4'h7);
    run({4'h0, 28'h000_0004}, 32'h0, 4'h7);
    run({4'h5, 8'h00, 20'h0_0000}, 32'h1, 4'h2);
  endtask
  // main sequence
  initial begin
    foreach (em[i]) em[i] = '0;
    {wave_create_in, mask_wr_en_in, go, two} = '0;
    {wave_create_id_in, mask_wr_wave_in, wv} = '0;
    {mask_wr_data_in, w0, w1} = '0;
    repeat (12) @(negedge sys_clk_in);
    chk("ready", 0, fetch_ready_out);
    chk("valid", 0, dec_valid_out);
    rst_b_in = 1'b1;
    mask_op(1'b1, 1'b0, 4'h2, '0);
    t_classes;
    t_literal;
    t_masks;
    tally_and_finish;
  end
  // watchdog, about 2000 cycles
  initial begin
    #100000;
    bad_count++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
